// File: see_pkg.sv
// Shared constants and types for the two-wire serial EEPROM target core.
`default_nettype none

package see_pkg;

  // Core clock rate and the self-timed programming interval.
  localparam int unsigned CORE_CLK_HZ    = 200_000_000;
  localparam int unsigned PROG_TIME_MS   = 5;
  localparam int unsigned PROG_CYCLES    = PROG_TIME_MS * (CORE_CLK_HZ / 1000);

  // Array organisation: 8-byte pages, word address width per capacity.
  localparam int unsigned PAGE_BYTES     = 8;
  localparam int unsigned PAGE_OFS_W     = 3;
  localparam int unsigned ADDR_W_1K      = 7;
  localparam int unsigned ADDR_W_2K      = 8;

  // Target address byte layout: fixed type code in the upper nibble.
  localparam logic [3:0]  DEV_TYPE_CODE  = 4'hA;
  localparam int unsigned TYPE_MSB       = 7;
  localparam int unsigned TYPE_LSB       = 4;
  localparam int unsigned CS_MSB         = 3;
  localparam int unsigned CS_LSB         = 1;
  localparam int unsigned RW_BIT         = 0;

  // Bit positions within a nine-clock byte frame.
  localparam logic [3:0]  BIT_FIRST      = 4'h0;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_ACK        = 4'h8;

  // Reset values.
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [5:0]  PIN_IDLE       = 6'h3F;

  // Receive buffer depth between the bit engine and the page latch.
  localparam int unsigned BUF_DEPTH      = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } see_state_t;

endpackage : see_pkg

`default_nettype wire

// File: see_buf2.sv
// Small valid/ready buffer built from flip-flops, two entries by default.
`default_nettype none

module see_buf2 #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk,       // Core clock.
  input  wire logic             rst_n,     // Asynchronous reset, active low.
  input  wire logic             in_valid,  // Producer offers a word.
  output logic                  in_ready,  // Buffer has room.
  input  wire logic [WIDTH-1:0] in_data,   // Word offered.
  output logic                  out_valid, // Buffer holds a word.
  input  wire logic             out_ready, // Consumer takes the word.
  output logic      [WIDTH-1:0] out_data   // Oldest word held.
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] ent_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != CNT_W'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = ent_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Payload storage needs no reset; the count guards every read.
  always_ff @(posedge clk) begin
    if (push) begin
      ent_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + CNT_W'(1);
    end else if (pop && !push) begin
      count_q <= count_q - CNT_W'(1);
    end
  end

endmodule : see_buf2

`default_nettype wire

// File: see_core.sv
// Target-side logic of a two-wire serial EEPROM with page writes and write protect.
`default_nettype none

module see_core #(
  parameter int unsigned ADDR_W      = see_pkg::ADDR_W_2K,
  parameter int unsigned PROG_CYCLES = see_pkg::PROG_CYCLES,
  parameter int unsigned BUF_DEPTH   = see_pkg::BUF_DEPTH
) (
  input  wire logic CORE_CLK,         // Core clock, 200 MHz.
  input  wire logic RESETN,           // Asynchronous reset, active low.
  input  wire logic SER_CLK,          // Serial clock from the bus controller.
  input  wire logic SER_DATA_I,       // Serial data line level.
  output logic      SER_DATA_O,       // Serial data drive value, always low.
  output logic      SER_DATA_OE_N,    // Serial data pull-down enable, active low.
  input  wire logic CHIP_SELECT_BIT2, // Hard-wired identity bit 2.
  input  wire logic CHIP_SELECT_BIT1, // Hard-wired identity bit 1.
  input  wire logic CHIP_SELECT_BIT0, // Hard-wired identity bit 0.
  input  wire logic WRITE_PROTECT,    // High blocks all array writes.
  output logic      PROG_BUSY         // Internal programming cycle running.
);

  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam int unsigned OW    = see_pkg::PAGE_OFS_W;
  localparam int unsigned ROW_W = ADDR_W - OW;
  localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int unsigned ENT_W = OW + 8;

  // ---------------------------------------------------------------
  // Serial clock domain: bit capture and open-drain drive.
  // ---------------------------------------------------------------
  logic [7:0] rx_sh_q;
  logic       oe_n_q;
  logic       tx_low_q;

  always_ff @(posedge SER_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_sh_q <= '0;
    end else begin
      rx_sh_q <= {rx_sh_q[6:0], SER_DATA_I};
    end
  end

  // The core settles tx_low_q just after a rising edge, so it is stable through
  // the rest of the high phase before this falling edge samples it.
  always_ff @(negedge SER_CLK or negedge RESETN) begin
    if (!RESETN) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~tx_low_q;
    end
  end

  assign SER_DATA_OE_N = oe_n_q;
  assign SER_DATA_O    = 1'b0;

  // ---------------------------------------------------------------
  // Core domain: pin synchronisers and bus condition detection.
  // ---------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl_r;
  logic       sda_r;
  logic [2:0] cs_pins;
  logic       wp_r;

  assign pin_raw = {WRITE_PROTECT, CHIP_SELECT_BIT2, CHIP_SELECT_BIT1,
                    CHIP_SELECT_BIT0, SER_DATA_I, SER_CLK};

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1_q <= see_pkg::PIN_IDLE;
      pin_s2_q <= see_pkg::PIN_IDLE;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign scl_r   = pin_s2_q[0];
  assign sda_r   = pin_s2_q[1];
  assign cs_pins = pin_s2_q[4:2];
  assign wp_r    = pin_s2_q[5];

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_r;
      sda_p_q <= sda_r;
    end
  end

  logic rise;
  logic start_ev;
  logic stop_ev;

  assign rise     = scl_r & ~scl_p_q;
  assign start_ev = scl_r & scl_p_q & sda_p_q & ~sda_r;
  assign stop_ev  = scl_r & scl_p_q & ~sda_p_q & sda_r;

  // ---------------------------------------------------------------
  // Byte framing.
  // ---------------------------------------------------------------
  see_pkg::see_state_t state_q;
  logic [3:0]          bit_q;
  logic                byte_done;
  logic                ack_clk;
  logic [7:0]          rx_byte;
  logic                dev_match;
  logic                master_ack;
  logic                busy_q;

  // The shift register holds still for a full serial clock period after the
  // edge that completed it, so the core may read it right after that edge.
  assign rx_byte    = rx_sh_q;
  assign master_ack = ~rx_sh_q[0];
  assign byte_done  = rise && (bit_q == see_pkg::BIT_LAST);
  assign ack_clk    = rise && (bit_q == see_pkg::BIT_ACK);

  assign dev_match = (rx_byte[see_pkg::TYPE_MSB:see_pkg::TYPE_LSB] == see_pkg::DEV_TYPE_CODE)
                  && (rx_byte[see_pkg::CS_MSB:see_pkg::CS_LSB] == cs_pins)
                  && !busy_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bit_q <= see_pkg::BIT_FIRST;
    end else if (start_ev) begin
      bit_q <= see_pkg::BIT_FIRST;
    end else if (rise) begin
      bit_q <= (bit_q == see_pkg::BIT_ACK) ? see_pkg::BIT_FIRST : bit_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer and word address.
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] word_addr_q;
  logic              push_valid;
  logic              push_ready;
  logic [ENT_W-1:0]  push_data;
  logic              drain_valid;
  logic [ENT_W-1:0]  drain_data;
  logic              rd_load;
  logic              first_q;
  logic [7:0]        rd_byte;
  logic [7:0]        mem_q [DEPTH];

  assign push_valid = byte_done && (state_q == see_pkg::ST_WDATA);
  assign push_data  = {word_addr_q[OW-1:0], rx_byte};
  assign rd_byte    = mem_q[word_addr_q];
  assign rd_load    = ack_clk && (state_q == see_pkg::ST_RDATA) && (first_q || master_ack);

  // Frames are ignored while programming, so stalling the drain while busy
  // costs nothing and keeps the page latch frozen during the array update.
  see_buf2 #(
    .WIDTH (ENT_W),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .clk       (CORE_CLK),
    .rst_n     (RESETN),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (drain_valid),
    .out_ready (!busy_q),
    .out_data  (drain_data)
  );

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      word_addr_q <= '0;
    end else if (byte_done && (state_q == see_pkg::ST_WADDR)) begin
      word_addr_q <= rx_byte[ADDR_W-1:0];
    end else if (push_valid && push_ready) begin
      word_addr_q <= {word_addr_q[ADDR_W-1:OW], word_addr_q[OW-1:0] + OW'(1)};
    end else if (rd_load) begin
      word_addr_q <= word_addr_q + ADDR_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Protocol state and outgoing bit selection.
  // ---------------------------------------------------------------
  logic [7:0] tx_sh_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q  <= see_pkg::ST_IDLE;
      tx_low_q <= 1'b0;
      tx_sh_q  <= '0;
      first_q  <= 1'b0;
    end else if (start_ev) begin
      state_q  <= busy_q ? see_pkg::ST_IGNORE : see_pkg::ST_DEVADDR;
      tx_low_q <= 1'b0;
    end else if (stop_ev) begin
      state_q  <= see_pkg::ST_IDLE;
      tx_low_q <= 1'b0;
    end else if (rise) begin
      case (state_q)
        see_pkg::ST_DEVADDR: begin
          if (bit_q == see_pkg::BIT_LAST) begin
            if (dev_match) begin
              tx_low_q <= 1'b1;
              first_q  <= 1'b1;
              state_q  <= rx_byte[see_pkg::RW_BIT] ? see_pkg::ST_RDATA : see_pkg::ST_WADDR;
            end else begin
              state_q <= see_pkg::ST_IGNORE;
            end
          end
        end
        see_pkg::ST_WADDR: begin
          if (bit_q == see_pkg::BIT_LAST) begin
            tx_low_q <= 1'b1;
            state_q  <= see_pkg::ST_WDATA;
          end else begin
            tx_low_q <= 1'b0;
          end
        end
        see_pkg::ST_WDATA: begin
          // A full buffer withholds the acknowledge rather than lose the byte.
          if (bit_q == see_pkg::BIT_LAST) begin
            tx_low_q <= push_ready;
          end else begin
            tx_low_q <= 1'b0;
          end
        end
        see_pkg::ST_RDATA: begin
          if (bit_q == see_pkg::BIT_ACK) begin
            if (rd_load) begin
              tx_low_q <= ~rd_byte[7];
              tx_sh_q  <= {rd_byte[6:0], 1'b0};
              first_q  <= 1'b0;
            end else begin
              tx_low_q <= 1'b0;
              state_q  <= see_pkg::ST_IGNORE;
            end
          end else if (bit_q == see_pkg::BIT_LAST) begin
            tx_low_q <= 1'b0;
          end else begin
            tx_low_q <= ~tx_sh_q[7];
            tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
          end
        end
        default: begin
          tx_low_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Page latch, commit and self-timed programming.
  // ---------------------------------------------------------------
  logic [7:0]            page_q [see_pkg::PAGE_BYTES];
  logic [see_pkg::PAGE_BYTES-1:0] mask_q;
  logic                  commit_pend_q;
  logic                  commit_go;
  logic                  prog_start;
  logic                  mask_clr;
  logic [CNT_W-1:0]      cnt_q;

  assign commit_go  = commit_pend_q && !drain_valid;
  assign prog_start = commit_go && !wp_r && (mask_q != '0);
  assign mask_clr   = commit_go || (start_ev && !commit_pend_q);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      commit_pend_q <= 1'b0;
    end else if (stop_ev && (state_q == see_pkg::ST_WDATA)) begin
      commit_pend_q <= 1'b1;
    end else if (commit_go) begin
      commit_pend_q <= 1'b0;
    end
  end

  for (genvar p = 0; p < see_pkg::PAGE_BYTES; p++) begin : g_page
    logic hit;
    assign hit = drain_valid && !busy_q && (drain_data[ENT_W-1:8] == OW'(p));

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
        page_q[p] <= see_pkg::ERASED_BYTE;
        mask_q[p] <= 1'b0;
      end else if (hit) begin
        page_q[p] <= drain_data[7:0];
        mask_q[p] <= 1'b1;
      end else if (mask_clr) begin
        mask_q[p] <= 1'b0;
      end
    end
  end

  // The array image updates at the start of the cycle; reads stay blocked
  // until the timer runs out, as the real cell would not be readable yet.
  for (genvar i = 0; i < DEPTH; i++) begin : g_array
    localparam int unsigned OFS = i % see_pkg::PAGE_BYTES;
    localparam int unsigned ROW = i / see_pkg::PAGE_BYTES;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
        mem_q[i] <= see_pkg::ERASED_BYTE;
      end else if (prog_start && (word_addr_q[ADDR_W-1:OW] == ROW_W'(ROW)) && mask_q[OFS]) begin
        mem_q[i] <= page_q[OFS];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (prog_start) begin
      cnt_q  <= CNT_W'(PROG_CYCLES);
      busy_q <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q  <= cnt_q - CNT_W'(1);
      busy_q <= (cnt_q > CNT_W'(1));
    end
  end

  assign PROG_BUSY = busy_q;

endmodule : see_core

`default_nettype wire

// File: see_core_props.sv
// Concurrent checks on the ports of the serial EEPROM target core.
`default_nettype none
module see_core_props #(
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic CORE_CLK,         // Core clock.
  input wire logic RESETN,           // Reset, active low.
  input wire logic SER_CLK,          // Serial clock.
  input wire logic SER_DATA_I,       // Data line level.
  input wire logic SER_DATA_O,       // Data drive value.
  input wire logic SER_DATA_OE_N,    // Pull-down enable, active low.
  input wire logic CHIP_SELECT_BIT2, // Identity bit 2.
  input wire logic CHIP_SELECT_BIT1, // Identity bit 1.
  input wire logic CHIP_SELECT_BIT0, // Identity bit 0.
  input wire logic WRITE_PROTECT,    // Write protect.
  input wire logic PROG_BUSY         // Programming cycle running.
);
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  // The busy length runs to a million cycles, so it is counted rather than repeated.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_cnt_q <= 32'h0000_0000;
    end else if (PROG_BUSY) begin
      busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
    end else begin
      busy_cnt_q <= 32'h0000_0000;
    end
  end
  a_drive_low_only: assert property (SER_DATA_O == 1'b0)
    else $error("data line drive value is high");
  a_change_on_fall: assert property ($changed(SER_DATA_OE_N) |-> !SER_CLK)
    else $error("data drive changed while serial clock high");
  a_busy_exact_len: assert property ($fell(PROG_BUSY) |-> busy_cnt_q == PROG_CYCLES)
    else $error("programming length differs");
  a_busy_bounded: assert property (busy_cnt_q <= PROG_CYCLES)
    else $error("programming runs too long");
  a_quiet_while_busy: assert property (PROG_BUSY && $past(PROG_BUSY) |-> SER_DATA_OE_N)
    else $error("data line pulled while programming");
  a_protect_blocks_prog: assert property ($rose(PROG_BUSY) |-> !WRITE_PROTECT)
    else $error("programming started while protected");
  a_prog_after_stop: assert property ($rose(PROG_BUSY) |-> SER_CLK && SER_DATA_I)
    else $error("programming started with bus not idle");
  a_busy_one_shot: assert property ($fell(PROG_BUSY) |=> !PROG_BUSY [*8])
    else $error("programming restarted without a new write");
  c_prog_done: cover property ($fell(PROG_BUSY));
  c_ack_seen: cover property ($fell(SER_DATA_OE_N));
  c_ack_protected: cover property (WRITE_PROTECT && $fell(SER_DATA_OE_N));
endmodule : see_core_props

bind see_core see_core_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SER_CLK(SER_CLK), .SER_DATA_I(SER_DATA_I),
  .SER_DATA_O(SER_DATA_O), .SER_DATA_OE_N(SER_DATA_OE_N), .CHIP_SELECT_BIT2(CHIP_SELECT_BIT2),
  .CHIP_SELECT_BIT1(CHIP_SELECT_BIT1), .CHIP_SELECT_BIT0(CHIP_SELECT_BIT0),
  .WRITE_PROTECT(WRITE_PROTECT), .PROG_BUSY(PROG_BUSY));
`default_nettype wire

// File: see_ctrl_model.sv
// Behavioural two-wire bus controller that frames transfers on the serial link.
`default_nettype none
module see_ctrl_model (
  output var logic scl,     // Serial clock, held high between frames.
  output var logic sda_rel, // Low pulls the data line down, high releases it.
  input  wire logic line    // Resolved data line with its pull-up.
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned low_extra;
  logic        obs_bit;
  logic [7:0]  obs_byte;
  event        obs_ev;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    low_extra = 0;
  end
  // Data moves 16 ns before the rising edge, mid-way through the low phase when low_extra is 0, well clear of both clock edges.
  task automatic put_bit(input logic b);
    #(16 + low_extra) sda_rel = b;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    #(16 + low_extra) sda_rel = 1'b1;
    #16 scl = 1'b1;
    #16 b = line;
    #16 scl = 1'b0;
  endtask : get_bit
  task automatic start_cond;
    #16 sda_rel = 1'b1;
    #16 scl = 1'b1;
    #32 sda_rel = 1'b0;
    #32 scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    #16 sda_rel = 1'b0;
    #16 scl = 1'b1;
    #32 sda_rel = 1'b1;
    #32;
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(a);
    obs_bit = a;
    -> obs_ev;
  endtask : send_byte
  task automatic recv_byte(input logic nack);
    logic [7:0] v;
    logic       b;
    for (int i = 0; i < 8; i++) begin
      get_bit(b);
      v = {v[6:0], b};
    end
    put_bit(nack);
    obs_byte = v;
    -> obs_ev;
  endtask : recv_byte
endmodule : see_ctrl_model
`default_nettype wire

// File: serial_eeprom_target_core_bench.sv
// Self-checking bench with a 2K and a 1K part sharing one two-wire bus.
`default_nettype none
module serial_eeprom_target_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PCYC = 400;
  typedef struct {
    logic       kind;
    logic [7:0] val;
  } see_note_t;
  logic            core_clk = 1'b0;
  logic            resetn = 1'b0;
  logic            wp = 1'b0;
  logic [2:0]      cs [2] = '{3'h0, 3'h5};
  logic [7:0]      mem [2][256];
  logic [7:0]      pg;
  wire logic [1:0] d_o, oe_n, busy;
  wire logic       scl, sda_rel;
  wire logic       line = sda_rel & (oe_n[0] | d_o[0]) & (oe_n[1] | d_o[1]);
  see_note_t       notes [$];
  see_note_t       cur;
  int              error_cnt = 0;
  int              checks_done = 0;
  int              cyc = 0;

  always #2.5 core_clk = ~core_clk;

  for (genvar g = 0; g < 2; g++) begin : g_part
    see_core #(
      .ADDR_W      (g ? see_pkg::ADDR_W_1K : see_pkg::ADDR_W_2K),
      .PROG_CYCLES (PCYC),
      .BUF_DEPTH   (see_pkg::BUF_DEPTH)
    ) dut (
      .CORE_CLK(core_clk), .RESETN(resetn), .SER_CLK(scl), .SER_DATA_I(line),
      .SER_DATA_O(d_o[g]), .SER_DATA_OE_N(oe_n[g]), .CHIP_SELECT_BIT2(cs[g][2]),
      .CHIP_SELECT_BIT1(cs[g][1]), .CHIP_SELECT_BIT0(cs[g][0]), .WRITE_PROTECT(wp),
      .PROG_BUSY(busy[g]));
  end
  see_ctrl_model ctrl (.scl(scl), .sda_rel(sda_rel), .line(line));

  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp_ack(input logic e, input logic s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD ack exp %b seen %b", e, s);
    end
  endtask : cmp_ack
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD read byte exp %h seen %h", e, s);
    end
  endtask : cmp_byte
  task automatic cmp_num(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %0d seen %0d", nm, e, s);
    end
  endtask : cmp_num
  task automatic put_note(input logic k, input logic [7:0] v);
    notes.push_back('{k, v});
  endtask : put_note
  function automatic logic [7:0] dev(input int p, input logic rd);
    return {see_pkg::DEV_TYPE_CODE, cs[p], rd};
  endfunction : dev
  task automatic set_addr(input int p, input logic [7:0] wa);
    ctrl.start_cond();
    put_note(1'b0, 8'h00);
    ctrl.send_byte(dev(p, 1'b0));
    put_note(1'b0, 8'h00);
    ctrl.send_byte(wa);
  endtask : set_addr
  task automatic write_page(input int p, input logic [7:0] wa, input int n);
    logic [7:0] v;
    logic [7:0] a;
    int         cnt;
    set_addr(p, wa);
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      a = {wa[7:3], wa[2:0] + 3'(i)};
      if (!wp) begin
        mem[p][a & (p ? 8'h7F : 8'hFF)] = v;
      end
      put_note(1'b0, 8'h00);
      ctrl.send_byte(v);
    end
    cnt = 0;
    // Programming starts before the STOP task returns, so counting begins ahead of it.
    fork
      repeat (PCYC + 200) begin
        @(negedge core_clk);
        if (busy[p] === 1'b1) begin
          cnt++;
        end
      end
      begin
        ctrl.stop_cond();
        if (!wp) begin
          ctrl.start_cond();
          put_note(1'b0, 8'h01);
          ctrl.send_byte(dev(p, 1'b0));
          ctrl.stop_cond();
        end
      end
    join
    if (wp) begin
      cmp_num("busy while protected", 16'h0000, 16'(cnt));
    end else begin
      cmp_num("busy cycles", 16'(PCYC), 16'(cnt));
    end
  endtask : write_page
  task automatic read_seq(input int p, input logic [7:0] wa, input int n);
    logic [7:0] a;
    set_addr(p, wa);
    ctrl.start_cond();
    put_note(1'b0, 8'h00);
    ctrl.send_byte(dev(p, 1'b1));
    a = wa & (p ? 8'h7F : 8'hFF);
    for (int i = 0; i < n; i++) begin
      put_note(1'b1, mem[p][a]);
      ctrl.recv_byte(i == n - 1);
      a = (a + 8'h01) & (p ? 8'h7F : 8'hFF);
    end
    ctrl.stop_cond();
  endtask : read_seq

  // Results are matched against the oldest expectation as the controller collects them.
  always @(ctrl.obs_ev) begin
    cur = notes.pop_front();
    if (cur.kind) begin
      cmp_byte(cur.val, ctrl.obs_byte);
    end else begin
      cmp_ack(cur.val[0], ctrl.obs_bit);
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(9));
    foreach (mem[p, a]) mem[p][a] = see_pkg::ERASED_BYTE;
    @(negedge core_clk);
    // Part 1 plays the strapless variant, so every frame to it carries zero select bits.
    cs[0] = 3'($urandom) | 3'h1;
    cs[1] = 3'h0;
    pg = 8'($urandom) & 8'hF8;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 2; i++) begin
      ctrl.start_cond();
      put_note(1'b0, 8'h01);
      ctrl.send_byte(i ? {4'hB, cs[0], 1'b0} : {see_pkg::DEV_TYPE_CODE, cs[0] ^ 3'h2, 1'b0});
      ctrl.stop_cond();
    end
    write_page(0, pg | 8'h05, 3);
    write_page(0, (pg ^ 8'h08) | 8'h06, 10);
    read_seq(0, pg, 8);
    read_seq(0, pg ^ 8'h08, 8);
    ctrl.low_extra = 40;
    read_seq(0, 8'hFE, 4);
    ctrl.low_extra = 0;
    write_page(1, 8'h85, 2);
    read_seq(1, 8'h7E, 10);
    repeat (8) @(negedge core_clk);
    wp = 1'b1;
    write_page(0, pg, 4);
    read_seq(0, pg, 8);
    report_and_stop();
  end
endmodule : serial_eeprom_target_core_bench
`default_nettype wire
